// ==== slpd_pkg.sv ====
// Package with states, error codes and timing constants of the lamp driver.
`default_nettype none
package slpd_pkg;
    localparam int CLK_HZ = 50_000_000;
    // Pattern time base step in microseconds; one step is one tick.
    localparam int TICK_US = 50_000;
    localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
    // Blink: on and off each this many ticks.
    localparam int BLINK_ON_TICKS = 4;
    // Flash: short on time, then long off at the end of a cycle.
    localparam int FLASH_ON_TICKS = 4;
    localparam int FLASH_GAP_TICKS = 4;
    localparam int FLASH_CYCLE_TICKS = 20;
    // Flicker: on and off each one tick.
    localparam int FLICKER_TICKS = 1;
    // Simulation step length in ticks.
    localparam int SIM_STEP_TICKS = 10;

    typedef enum logic [1:0] {
        SLPD_ST_INIT,
        SLPD_ST_PREOP,
        SLPD_ST_SAFEOP,
        SLPD_ST_OP
    } slpd_bus_state_t;

    typedef enum logic [1:0] {
        SLPD_ERR_NONE,
        SLPD_ERR_SETTING,
        SLPD_ERR_DATA,
        SLPD_ERR_WATCHDOG
    } slpd_err_t;

    typedef enum logic [1:0] {
        SLPD_SIM_POWER,
        SLPD_SIM_ALARM,
        SLPD_SIM_BOTH
    } slpd_sim_step_t;
endpackage
`default_nettype wire

// ==== slpd_timebase.sv ====
// Shared time base: tick enable and pattern waveforms for all lamps.
`timescale 1ns/1ps
`default_nettype none
module slpd_timebase #(
    parameter int TICK_CYCLES = slpd_pkg::TICK_CYCLES,
    parameter int BLINK_TICKS = slpd_pkg::BLINK_ON_TICKS,
    parameter int FLASH_TICKS = slpd_pkg::FLASH_ON_TICKS,
    parameter int GAP_TICKS = slpd_pkg::FLASH_GAP_TICKS,
    parameter int CYCLE_TICKS = slpd_pkg::FLASH_CYCLE_TICKS
) (
    input wire logic clk,
    input wire logic reset_n,
    output logic tick,
    output logic blink,
    output logic single_flash,
    output logic double_flash,
    output logic flicker
);
    import slpd_pkg::*;

    localparam int DIV_W = $clog2(TICK_CYCLES + 1);
    localparam int PH_W = 8;

    initial begin
        if (TICK_CYCLES < 1 || BLINK_TICKS < 1 || FLASH_TICKS < 1 ||
            GAP_TICKS < 1 ||
            CYCLE_TICKS <= 2 * (FLASH_TICKS + GAP_TICKS) ||
            CYCLE_TICKS > 255 || 2 * BLINK_TICKS > 256) begin
            $error("slpd_timebase: pattern periods cannot be served");
        end
    end

    logic [DIV_W-1:0] div_q;
    logic [PH_W-1:0] blink_q;
    logic [PH_W-1:0] cyc_q;

    // ========================================================
    // Clock divider giving a one-cycle tick enable.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            div_q <= '0;
            tick <= 1'b0;
        end else if (div_q == DIV_W'(TICK_CYCLES - 1)) begin
            div_q <= '0;
            tick <= 1'b1;
        end else begin
            div_q <= div_q + 1'b1;
            tick <= 1'b0;
        end
    end

    // ========================================================
    // Phase counters of the patterns, stepped once per tick.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            blink_q <= '0;
            cyc_q <= '0;
        end else if (tick) begin
            if (blink_q == PH_W'(2 * BLINK_TICKS - 1)) begin
                blink_q <= '0;
            end else begin
                blink_q <= blink_q + 1'b1;
            end
            if (cyc_q == PH_W'(CYCLE_TICKS - 1)) begin
                cyc_q <= '0;
            end else begin
                cyc_q <= cyc_q + 1'b1;
            end
        end
    end

    // ========================================================
    // Waveforms: flashes differ by count of pulses per cycle.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            blink <= 1'b0;
            single_flash <= 1'b0;
            double_flash <= 1'b0;
            flicker <= 1'b0;
        end else begin
            blink <= blink_q < PH_W'(BLINK_TICKS);
            single_flash <= cyc_q < PH_W'(FLASH_TICKS);
            double_flash <= (cyc_q < PH_W'(FLASH_TICKS)) ||
                ((cyc_q >= PH_W'(FLASH_TICKS + GAP_TICKS)) &&
                 (cyc_q < PH_W'(2 * FLASH_TICKS + GAP_TICKS)));
            if (tick) begin
                flicker <= ~flicker;
            end
        end
    end
endmodule
`default_nettype wire

// ==== slpd_top.sv ====
// Status lamp pattern driver: network lamps and per-axis lamps.
// Behaviour
// - Run lamp is dark in init, blinks in pre-op, single-flashes in safe-op and is lit in op.
// - Fault lamp is dark with no error, blinks on setting error, single-flashes on data error, double-flashes on watchdog timeout.
// - Link lamp is dark without link, lit with link, and flickers with traffic on a link.
// - Each axis power lamp is lit with control power, and its alarm lamp blinks on alarm.
// - Information or remote operation blinks power and alarm lamps together twice per repetition.
// - Simulation lights power, then alarm, then both, repeating while it lasts.
`timescale 1ns/1ps
`default_nettype none
module slpd_top #(
    parameter int AXES = 4,
    parameter int TICK_CYCLES = slpd_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire slpd_pkg::slpd_bus_state_t bus_state,
    input wire slpd_pkg::slpd_err_t comm_error,
    input wire logic link_up,
    input wire logic link_traffic,
    input wire logic [AXES-1:0] ctrl_power,
    input wire logic [AXES-1:0] alarm,
    input wire logic [AXES-1:0] info,
    input wire logic [AXES-1:0] remote_op,
    input wire logic [AXES-1:0] simulating,
    output logic run_lamp,
    output logic fault_lamp,
    output logic link_lamp,
    output logic [AXES-1:0] power_lamp,
    output logic [AXES-1:0] alarm_lamp
);
    import slpd_pkg::*;

    initial begin
        if (AXES < 1 || AXES > 16) begin
            $error("slpd_top: AXES out of range");
        end
    end

    logic tick;
    logic blink;
    logic single_flash;
    logic double_flash;
    logic flicker;
    logic [7:0] sim_cnt_q;
    slpd_sim_step_t sim_step_q;

    slpd_timebase #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timebase (
        .clk(clk),
        .reset_n(reset_n),
        .tick(tick),
        .blink(blink),
        .single_flash(single_flash),
        .double_flash(double_flash),
        .flicker(flicker)
    );

    // ========================================================
    // Network lamps.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            run_lamp <= 1'b0;
        end else begin
            case (bus_state)
                SLPD_ST_INIT: run_lamp <= 1'b0;
                SLPD_ST_PREOP: run_lamp <= blink;
                SLPD_ST_SAFEOP: run_lamp <= single_flash;
                SLPD_ST_OP: run_lamp <= 1'b1;
                default: run_lamp <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fault_lamp <= 1'b0;
        end else begin
            case (comm_error)
                SLPD_ERR_NONE: fault_lamp <= 1'b0;
                SLPD_ERR_SETTING: fault_lamp <= blink;
                SLPD_ERR_DATA: fault_lamp <= single_flash;
                SLPD_ERR_WATCHDOG: fault_lamp <= double_flash;
                default: fault_lamp <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            link_lamp <= 1'b0;
        end else if (!link_up) begin
            link_lamp <= 1'b0;
        end else if (link_traffic) begin
            link_lamp <= flicker;
        end else begin
            link_lamp <= 1'b1;
        end
    end

    // ========================================================
    // Simulation step sequencer, shared by all axes.
    always_ff @(posedge clk) begin
        if (!reset_n || simulating == '0) begin
            sim_cnt_q <= '0;
            sim_step_q <= SLPD_SIM_POWER;
        end else if (tick) begin
            if (sim_cnt_q == 8'(SIM_STEP_TICKS - 1)) begin
                sim_cnt_q <= '0;
                case (sim_step_q)
                    SLPD_SIM_POWER: sim_step_q <= SLPD_SIM_ALARM;
                    SLPD_SIM_ALARM: sim_step_q <= SLPD_SIM_BOTH;
                    default: sim_step_q <= SLPD_SIM_POWER;
                endcase
            end else begin
                sim_cnt_q <= sim_cnt_q + 1'b1;
            end
        end
    end

    // ========================================================
    // Per-axis lamps; simulation outranks info, which outranks alarm.
    for (genvar i = 0; i < AXES; i++) begin : g_axis
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                power_lamp[i] <= 1'b0;
                alarm_lamp[i] <= 1'b0;
            end else if (simulating[i]) begin
                power_lamp[i] <= sim_step_q != SLPD_SIM_ALARM;
                alarm_lamp[i] <= sim_step_q != SLPD_SIM_POWER;
            end else if (info[i] || remote_op[i]) begin
                power_lamp[i] <= double_flash;
                alarm_lamp[i] <= double_flash;
            end else begin
                power_lamp[i] <= ctrl_power[i];
                alarm_lamp[i] <= alarm[i] && blink;
            end
        end
    end
endmodule
`default_nettype wire

// ==== slpd_lamp_obs.sv ====
// Operator model: counts lit cycles and turn-ons of one lamp.
`timescale 1ns/1ps
`default_nettype none
module slpd_lamp_obs (
    input wire logic clk,
    input wire logic clear,
    input wire logic lamp,
    output int lit,
    output int ons
);
    logic prev;
    always @(posedge clk) begin
        if (clear) begin
            lit <= 0;
            ons <= 0;
        end else begin
            lit <= lit + int'(lamp);
            ons <= ons + int'(lamp && !prev);
        end
        prev <= lamp;
    end
endmodule
`default_nettype wire

// ==== slpd_top_asserts.sv ====
// Checker of the lamp driver outputs.
`timescale 1ns/1ps
`default_nettype none
module slpd_top_asserts #(
    parameter int AXES = 4,
    parameter int TICK_CYCLES = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire slpd_pkg::slpd_bus_state_t bus_state,
    input wire slpd_pkg::slpd_err_t comm_error,
    input wire logic link_up,
    input wire logic link_traffic,
    input wire logic [AXES-1:0] ctrl_power,
    input wire logic [AXES-1:0] alarm,
    input wire logic [AXES-1:0] info,
    input wire logic [AXES-1:0] remote_op,
    input wire logic [AXES-1:0] simulating,
    input wire logic run_lamp,
    input wire logic fault_lamp,
    input wire logic link_lamp,
    input wire logic [AXES-1:0] power_lamp,
    input wire logic [AXES-1:0] alarm_lamp
);
    import slpd_pkg::*;
    wire logic plain = !info[0] && !remote_op[0] && !simulating[0];
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_up;
        reset_n ##1 reset_n;
    endsequence
    a_run_dark: assert property (
        bus_state == SLPD_ST_INIT |=> !run_lamp) else $error("run lit");
    a_run_lit: assert property (
        s_up ##0 bus_state == SLPD_ST_OP |=> run_lamp) else $error("run off");
    a_fault_dark: assert property (
        comm_error == SLPD_ERR_NONE |=> !fault_lamp) else $error("fault lit");
    a_link_dark: assert property (
        !link_up |=> !link_lamp) else $error("link lit");
    a_link_lit: assert property (
        s_up ##0 link_up && !link_traffic |=> link_lamp) else $error("link off");
    a_power_lit: assert property (
        s_up ##0 plain && ctrl_power[0] |=> power_lamp[0]) else $error("pwr");
    a_alarm_dark: assert property (
        plain && !alarm[0] |=> !alarm_lamp[0]) else $error("alarm lit");
    a_info_pair: assert property (
        (info[0] || remote_op[0]) && !simulating[0]
        |=> power_lamp[0] == alarm_lamp[0]) else $error("info apart");
    a_sim_lit: assert property (
        simulating[0] |=> power_lamp[0] || alarm_lamp[0])
        else $error("sim dark");
endmodule
bind slpd_top slpd_top_asserts #(.AXES(AXES), .TICK_CYCLES(TICK_CYCLES))
    u_asserts (.clk(clk), .reset_n(reset_n), .bus_state(bus_state),
    .comm_error(comm_error), .link_up(link_up), .link_traffic(link_traffic),
    .ctrl_power(ctrl_power), .alarm(alarm), .info(info),
    .remote_op(remote_op), .simulating(simulating), .run_lamp(run_lamp),
    .fault_lamp(fault_lamp), .link_lamp(link_lamp),
    .power_lamp(power_lamp), .alarm_lamp(alarm_lamp));
`default_nettype wire

// ==== slpd_top_tb.sv ====
// Random tests of the lamp driver, judged by lamp observers.
`timescale 1ns/1ps
`default_nettype none
module slpd_top_tb;
    import slpd_pkg::*;
    localparam int AX = 4;
    localparam int NL = 2 * AX + 3;
    localparam int WIN = 480;
    // Lit cycles and turn-ons per window for each pattern code.
    localparam int E_LIT [8] = '{0, WIN, 240, 96, 192, 240, 320, 320};
    localparam int E_ONS [8] = '{0, 0, 15, 6, 12, 60, 4, 4};
    logic clk = 0;
    logic reset_n = 0;
    logic clear = 0;
    logic link_up = 0;
    logic link_traffic = 0;
    slpd_bus_state_t bus_state = SLPD_ST_INIT;
    slpd_err_t comm_error = SLPD_ERR_NONE;
    logic [AX-1:0] ctrl_power = '0, alarm = '0, info = '0;
    logic [AX-1:0] remote_op = '0, simulating = '0;
    wire logic [NL-1:0] lamps;
    int lit [NL];
    int ons [NL];
    int n_mismatch = 0;
    int checked = 0;
    slpd_top #(.AXES(AX), .TICK_CYCLES(4)) DUT (
        .clk(clk), .reset_n(reset_n), .bus_state(bus_state),
        .comm_error(comm_error), .link_up(link_up),
        .link_traffic(link_traffic), .ctrl_power(ctrl_power),
        .alarm(alarm), .info(info), .remote_op(remote_op),
        .simulating(simulating), .run_lamp(lamps[0]),
        .fault_lamp(lamps[1]), .link_lamp(lamps[2]),
        .power_lamp(lamps[AX+2:3]), .alarm_lamp(lamps[NL-1:AX+3]));
    for (genvar i = 0; i < NL; i++) begin : g_obs
        slpd_lamp_obs u_obs (.clk(clk), .clear(clear), .lamp(lamps[i]),
            .lit(lit[i]), .ons(ons[i]));
    end
    function automatic int pat(int i);
        int rt [4] = '{0, 2, 3, 1};
        int ft [4] = '{0, 2, 3, 4};
        int a = (i - 3) % AX;
        if (i == 0) return rt[bus_state];
        if (i == 1) return ft[comm_error];
        if (i == 2) return link_up ? (link_traffic ? 5 : 1) : 0;
        if (simulating[a]) return i < AX + 3 ? 6 : 7;
        if (info[a] || remote_op[a]) return 4;
        if (i < AX + 3) return ctrl_power[a] ? 1 : 0;
        return alarm[a] ? 2 : 0;
    endfunction
    task automatic check(int i);
        int p = pat(i);
        checked++;
        if (lit[i] != E_LIT[p] || ons[i] != E_ONS[p]) begin
            n_mismatch++;
            $display("BAD %0t lamp %0d lit %0h exp %0h ons %0h exp %0h",
                $time, i, lit[i], E_LIT[p], ons[i], E_ONS[p]);
        end
    endtask
    task automatic results();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        #400000;
        n_mismatch++;
        results();
    end
    initial begin
        void'($urandom(24978));
        repeat (2) @(posedge clk);
        reset_n <= 1;
        for (int n = 0; n < 24; n++) begin
            @(posedge clk);
            bus_state <= slpd_bus_state_t'(n[1:0]);
            comm_error <= slpd_err_t'(n[3:2]);
            {link_up, link_traffic} <= 2'($urandom);
            {ctrl_power, alarm} <= (2*AX)'($urandom);
            info <= AX'($urandom & $urandom & $urandom);
            remote_op <= AX'($urandom & $urandom & $urandom);
            simulating <= AX'($urandom & $urandom & $urandom);
            repeat (8) @(posedge clk);
            clear <= 1;
            @(posedge clk);
            clear <= 0;
            repeat (WIN) @(posedge clk);
            #1;
            check(0);
            check(1);
            check(2);
            for (int i = 3; i < NL; i++) check(i);
        end
        results();
    end
endmodule
`default_nettype wire
